/* vcat_map.vh */
// Register map constants for the VC0 control, status and arbitration table bank.
// Assumes byte addressing on a 32-bit AHB-Lite bus; one aligned word per register.
`ifndef VCAT_MAP_VH
`define VCAT_MAP_VH
// ------------------------------------------------------------
// Offsets
// ------------------------------------------------------------
`define VCAT_OFF_CONTROL 12'h214
`define VCAT_OFF_STATUS 12'h218
`define VCAT_OFF_TABLE0 12'h220
`define VCAT_OFF_TABLE1 12'h224
`define VCAT_OFF_ARBCFG 12'h230
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define VCAT_CTL_CHANNEL_ON 31
`define VCAT_CTL_LOAD_REQ 16
`define VCAT_STS_DIRTY 0
`define VCAT_STS_NEG_PEND 1
`define VCAT_CFG_TABLE_USED 0
`define VCAT_CFG_ARB_RUN 1
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define VCAT_RST_TABLE0 32'h17654321
`define VCAT_RST_TABLE1 32'h21765432
`define VCAT_RST_ARBCFG 32'h00000003
// ------------------------------------------------------------
// Port ID codes and timing
// ------------------------------------------------------------
`define VCAT_PORT_UP 4'h0
`define VCAT_PORT_MIN 4'h2
`define VCAT_PORT_MAX 4'h5
`define VCAT_LOAD_CYCLES 4'h4
`endif

/* vcat_regs.v */
// VC0 register bank: control, status, two arbitration table words and a phase walker.
// Assumes a single AHB-Lite master on clk_in; port straps are static in operation.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "vcat_map.vh"

// Summary of operation
// - Channel enable bit 31 of control always reads one; writes ignored.
// - Any software write to a table word sets the dirty flag.
// - Dirty flag stays set until a requested table load completes.
// - Dirty flag is meaningful only when the arbitration scheme uses the table.
// - Downstream ports always read the dirty flag as zero.
// - Status bit 1 shows flow control initialization still in progress.
// - Phases are 4-bit RW fields, eight per word, lowest phase low.
// - Phase with invalid port ID is skipped with no idle slot.
// - Code 0 is upstream port 0, 2 to 5 ports 2-5, 6-F reserved.
// - Word 0 resets to phases 0-7 as 1,2,3,4,5,6,7,1.
// - Word 1 resets to phases 8-15 as 2,3,4,5,6,7,1,2.
// - Load request bit copies table to arbiter, upstream only; reads zero.
module vcat_regs #(
   parameter PHASES = 16,
   parameter ARB_DIV = 8
) (
   input wire clk_in,
   input wire nrst_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   input wire upstream_port_in,
   input wire fc_init_done_in,
   input wire [3:0] egress_port_id_in,
   output reg [31:0] hrdata_out,
   output reg hreadyout_out,
   output reg hresp_out,
   output reg [3:0] grant_port_out,
   output reg grant_valid_out,
   output reg [4:0] grant_phase_out
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function is_valid_port;
      input [3:0] id;
      input [3:0] egress;
      begin
         is_valid_port = ((id == `VCAT_PORT_UP) ||
            ((id >= `VCAT_PORT_MIN) && (id <= `VCAT_PORT_MAX))) && (id != egress);
      end
   endfunction

   function [3:0] phase_of;
      input [63:0] tbl;
      input [3:0] idx;
      begin
         phase_of = tbl[idx*4 +: 4];
      end
   endfunction

   function addr_is;
      input [11:0] addr;
      input [11:0] off;
      begin
         addr_is = (addr == off);
      end
   endfunction

   function [31:0] status_word;
      input dirty;
      input upstream;
      input used;
      input fc_done;
      begin
         status_word = 32'h00000000;
         status_word[`VCAT_STS_DIRTY] = dirty && upstream && used;
         status_word[`VCAT_STS_NEG_PEND] = !fc_done;
      end
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Straps and the flow control flag come from outside this clock domain
   // Upstream strap
   reg up_s1_r;
   reg up_s2_r;
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         up_s1_r <= 1'b0;
         up_s2_r <= 1'b0;
      end else begin
         up_s1_r <= upstream_port_in;
         up_s2_r <= up_s1_r;
      end
   end

   // Flow control init done
   reg fc_s1_r;
   reg fc_s2_r;
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fc_s1_r <= 1'b0;
         fc_s2_r <= 1'b0;
      end else begin
         fc_s1_r <= fc_init_done_in;
         fc_s2_r <= fc_s1_r;
      end
   end

   // Egress port ID
   reg [3:0] eg_s1_r;
   reg [3:0] eg_s2_r;
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         eg_s1_r <= 4'h0;
         eg_s2_r <= 4'h0;
      end else begin
         eg_s1_r <= egress_port_id_in;
         eg_s2_r <= eg_s1_r;
      end
   end

   // ------------------------------------------------------------
   // AHB-Lite address phase capture
   // ------------------------------------------------------------
   reg wr_pend_r;
   reg [11:0] wr_addr_r;
   wire take = hsel_in && htrans_in[1] && hready_in;
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
      end else begin
         wr_pend_r <= take && hwrite_in;
         if (take)
            wr_addr_r <= haddr_in[11:0];
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [63:0] table_r;
   reg [63:0] loaded_r;
   reg [31:0] arbcfg_r;
   reg dirty_r;
   reg loading_r;
   reg [3:0] load_cnt_r;
   wire wr_tbl0 = wr_pend_r && addr_is(wr_addr_r, `VCAT_OFF_TABLE0);
   wire wr_tbl1 = wr_pend_r && addr_is(wr_addr_r, `VCAT_OFF_TABLE1);
   wire wr_ctl = wr_pend_r && addr_is(wr_addr_r, `VCAT_OFF_CONTROL);
   wire wr_cfg = wr_pend_r && addr_is(wr_addr_r, `VCAT_OFF_ARBCFG);
   wire load_req = wr_ctl && hwdata_in[`VCAT_CTL_LOAD_REQ] && up_s2_r;
   // A request in the last count cycle restarts the load instead of finishing it
   wire load_done = loading_r && (load_cnt_r == 4'h1) && !load_req;
   wire tbl_used = arbcfg_r[`VCAT_CFG_TABLE_USED];
   wire arb_run = arbcfg_r[`VCAT_CFG_ARB_RUN];

   // Stored table, written only by software
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         table_r <= {`VCAT_RST_TABLE1, `VCAT_RST_TABLE0};
      end else begin
         if (wr_tbl0)
            table_r[31:0] <= hwdata_in;
         if (wr_tbl1)
            table_r[63:32] <= hwdata_in;
      end
   end

   // ------------------------------------------------------------
   // Configuration register
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         arbcfg_r <= `VCAT_RST_ARBCFG;
      else if (wr_cfg)
         arbcfg_r <= {30'h0, hwdata_in[1:0]};
   end

   // ------------------------------------------------------------
   // Load sequencer
   // ------------------------------------------------------------
   localparam LD_IDLE = 1'b0;
   localparam LD_BUSY = 1'b1;

   // Counts down from the request, then the arbiter copy follows
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         loading_r <= LD_IDLE;
         load_cnt_r <= 4'h0;
      end else begin
         case (loading_r)
            LD_IDLE: begin
               if (load_req) begin
                  loading_r <= LD_BUSY;
                  load_cnt_r <= `VCAT_LOAD_CYCLES;
               end
            end
            LD_BUSY: begin
               if (load_req) begin
                  load_cnt_r <= `VCAT_LOAD_CYCLES;
               end else if (load_done) begin
                  loading_r <= LD_IDLE;
                  load_cnt_r <= 4'h0;
               end else begin
                  load_cnt_r <= load_cnt_r - 4'h1;
               end
            end
            default: begin
               loading_r <= LD_IDLE;
               load_cnt_r <= 4'h0;
            end
         endcase
      end
   end

   // Snapshot that the arbiter walks
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         loaded_r <= {`VCAT_RST_TABLE1, `VCAT_RST_TABLE0};
      else if (load_done)
         loaded_r <= table_r;
   end

   // ------------------------------------------------------------
   // Table coherency flag
   // ------------------------------------------------------------
   // A table write wins over a completing load
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         dirty_r <= 1'b0;
      else if (wr_tbl0 || wr_tbl1)
         dirty_r <= 1'b1;
      else if (load_done)
         dirty_r <= 1'b0;
   end

   // ------------------------------------------------------------
   // Read data and response
   // ------------------------------------------------------------
   reg [31:0] rdata_nxt;
   always @* begin
      rdata_nxt = 32'h00000000;
      case (haddr_in[11:0])
         `VCAT_OFF_CONTROL:
            rdata_nxt[`VCAT_CTL_CHANNEL_ON] = 1'b1;
         `VCAT_OFF_STATUS:
            rdata_nxt = status_word(dirty_r, up_s2_r, tbl_used, fc_s2_r);
         `VCAT_OFF_TABLE0:
            rdata_nxt = table_r[31:0];
         `VCAT_OFF_TABLE1:
            rdata_nxt = table_r[63:32];
         `VCAT_OFF_ARBCFG:
            rdata_nxt = arbcfg_r;
         default:
            rdata_nxt = 32'h00000000;
      endcase
   end

   // Read data launched in the address phase stands through the data phase
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         hrdata_out <= 32'h00000000;
      else if (take && !hwrite_in)
         hrdata_out <= rdata_nxt;
   end

   // ------------------------------------------------------------
   // Bus response: zero wait state, always OKAY
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Phase walker
   // ------------------------------------------------------------
   reg [7:0] div_r;
   reg [3:0] phase_r;
   wire tick = (div_r == 8'h00);
   reg [3:0] pick_idx;
   reg pick_ok;
   integer k;
   // Search ahead so invalid phases cost no slot
   always @* begin
      pick_idx = phase_r;
      pick_ok = 1'b0;
      for (k = PHASES - 1; k >= 0; k = k - 1) begin
         if (is_valid_port(phase_of(loaded_r, phase_r + k[3:0]), eg_s2_r)) begin
            pick_idx = phase_r + k[3:0];
            pick_ok = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Arbitration period divider
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         div_r <= 8'h00;
      else if (!arb_run)
         div_r <= 8'h00;
      else if (tick)
         div_r <= ARB_DIV[7:0] - 8'h01;
      else
         div_r <= div_r - 8'h01;
   end

   // ------------------------------------------------------------
   // Grant register
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         phase_r <= 4'h0;
         grant_port_out <= 4'h0;
         grant_valid_out <= 1'b0;
         grant_phase_out <= 5'h00;
      end else begin
         grant_valid_out <= 1'b0;
         if (arb_run && tick && pick_ok) begin
            grant_port_out <= phase_of(loaded_r, pick_idx);
            grant_phase_out <= {1'b0, pick_idx};
            grant_valid_out <= 1'b1;
            phase_r <= pick_idx + 4'h1;
         end
      end
   end

endmodule

/* vcat_regs_sva.sv */
// Checker for vcat_regs: status reads and grant outputs.
// Bound from the testbench; straps are held steady between changes.
`timescale 1ns/100ps
module vcat_regs_sva (
   input wire clk_in,
   input wire nrst_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire hready_in,
   input wire upstream_port_in,
   input wire fc_init_done_in,
   input wire [3:0] egress_port_id_in,
   input wire [31:0] hrdata_out,
   input wire [3:0] grant_port_out,
   input wire grant_valid_out,
   input wire [4:0] grant_phase_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   sequence rd_at(a);
      hsel_in && htrans_in[1] && hready_in && !hwrite_in && haddr_in[11:0] == a;
   endsequence
   chk_chan_on: assert property (
      rd_at(12'h214) |=> hrdata_out[31] && !hrdata_out[16]) else $error("control bits wrong");
   chk_sts_rsvd: assert property (
      rd_at(12'h218) |=> hrdata_out[31:2] == 30'h0) else $error("status upper bits set");
   chk_neg_pend: assert property (
      ($stable(fc_init_done_in) [*4] ##0 rd_at(12'h218)) |=> hrdata_out[1] != fc_init_done_in)
      else $error("pending bit wrong");
   chk_dirty_down: assert property (
      (!upstream_port_in [*4] ##0 rd_at(12'h218)) |=> !hrdata_out[0]) else $error("dirty set");
   chk_grant_code: assert property (
      grant_valid_out |-> grant_port_out == 4'h0 || (grant_port_out >= 4'h2 &&
      grant_port_out <= 4'h5)) else $error("grant to reserved code");
   chk_grant_egress: assert property (
      grant_valid_out |-> grant_port_out != egress_port_id_in) else $error("grant to egress");
   chk_grant_range: assert property (
      grant_valid_out |-> grant_phase_out < 5'h10) else $error("grant phase out of range");
   chk_grant_pulse: assert property (
      grant_valid_out |=> !grant_valid_out [*7]) else $error("grants too close");
endmodule

/* vcat_regs_tb.sv */
// Self-checking bench for vcat_regs: AHB-Lite register access and grants.
// Bench is the single bus master; hready follows the slave's hreadyout.
`timescale 1ns/100ps
`include "vcat_map.vh"
module vcat_regs_tb;
   reg clk_in = 1'b0;
   reg nrst_in = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [31:0] hwdata = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg up = 1'b1;
   reg fc = 1'b0;
   reg rd_dp = 1'b0;
   reg [3:0] egr = 4'h3;
   reg [31:0] w0, e, m;
   reg [3:0] exp_ph = 4'h0;
   reg [3:0] p;
   reg [63:0] ld_tbl = {`VCAT_RST_TABLE1, `VCAT_RST_TABLE0};
   logic [31:0] exp_q[$], msk_q[$];
   int bad_count = 0;
   int total_checks = 0;
   wire [31:0] hrdata_out;
   wire hreadyout_out, grant_valid_out, hresp_out;
   wire [3:0] grant_port_out;
   wire [4:0] grant_phase_out;
   always #20 clk_in = ~clk_in;
   vcat_regs vcat_regs_inst (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(1'b1),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hreadyout_out), .upstream_port_in(up),
      .fc_init_done_in(fc), .egress_port_id_in(egr), .hrdata_out(hrdata_out),
      .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .grant_port_out(grant_port_out),
      .grant_valid_out(grant_valid_out), .grant_phase_out(grant_phase_out));
   // --------------------------------
   // Bus master and result watcher
   // --------------------------------
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task wait_rdy;
      int n;
      n = 0;
      @(posedge clk_in);
      while (hreadyout_out !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk_in);
      end
      if (n == 20) begin
         $display("ERROR hreadyout_out exp 1 got %b", hreadyout_out);
         bad_count++;
         report_and_stop;
      end
   endtask
   task xfer(input bit w, input [11:0] a, input [31:0] d, input [31:0] msk);
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      rd_dp <= !w;
      if (!w) begin
         exp_q.push_back(d);
         msk_q.push_back(msk);
      end
      wait_rdy;
      rd_dp <= 1'b0;
   endtask
   function automatic [31:0] rnd_word;
      for (int i = 0; i < 8; i++) rnd_word[i*4 +: 4] = 4'(16'h5420 >> (4 * ($urandom % 4)));
   endfunction
   function automatic bit port_ok(input [3:0] c);
      return (c == 4'h0 || (c >= 4'h2 && c <= 4'h5)) && c != egr;
   endfunction
   always @(posedge clk_in) begin
      if (rd_dp) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         total_checks++;
         if ({hresp_out, hrdata_out & m} !== {1'b0, e & m}) begin
            $display("ERROR hrdata_out exp %h got %h", {1'b0, e & m},
               {hresp_out, hrdata_out & m});
            bad_count++;
         end
      end
      if (grant_valid_out === 1'b1) begin
         p = exp_ph;
         for (int j = 0; j < 16 && !port_ok(ld_tbl[p*4 +: 4]); j++) p = p + 4'h1;
         exp_ph = p + 4'h1;
         total_checks++;
         if ({grant_phase_out, grant_port_out} !== {1'b0, p, ld_tbl[p*4 +: 4]}) begin
            $display("ERROR grant exp %h got %h", {1'b0, p, ld_tbl[p*4 +: 4]},
               {grant_phase_out, grant_port_out});
            bad_count++;
         end
      end
   end
   initial begin
      void'($urandom(60));
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      xfer(0, 12'h214, 32'h80000000, 32'h80010000);
      xfer(0, 12'h218, 32'h2, '1);
      xfer(0, 12'h220, `VCAT_RST_TABLE0, '1);
      xfer(0, 12'h224, `VCAT_RST_TABLE1, '1);
      xfer(0, 12'h2F0, 32'h0, '1);
      repeat (200) @(posedge clk_in);
      $display("test 1 done");
      xfer(1, 12'h214, 32'h0, 0);
      xfer(0, 12'h214, 32'h80000000, 32'h80010000);
      xfer(1, 12'h230, 32'h1, 0);
      for (int k = 0; k < 2; k++) begin
         w0 = rnd_word();
         xfer(1, 12'h220 + 12'(k * 4), w0, 0);
         xfer(0, 12'h220 + 12'(k * 4), w0, '1);
         xfer(0, 12'h218, {30'h0, !fc, 1'b1}, '1);
         xfer(1, 12'h230, 32'h0, 0);
         xfer(0, 12'h218, {30'h0, !fc, 1'b0}, '1);
         xfer(1, 12'h230, 32'h1, 0);
         fc <= 1'b1;
         xfer(1, 12'h214, 32'h00010000, 0);
         repeat (6) @(posedge clk_in);
         xfer(0, 12'h218, 32'h0, '1);
         ld_tbl[k*32 +: 32] = w0;
      end
      xfer(1, 12'h230, 32'h3, 0);
      repeat (300) @(posedge clk_in);
      $display("test 2 done");
      up <= 1'b0;
      xfer(1, 12'h220, rnd_word(), 0);
      xfer(1, 12'h214, 32'h00010000, 0);
      repeat (6) @(posedge clk_in);
      xfer(0, 12'h218, 32'h0, '1);
      repeat (200) @(posedge clk_in);
      $display("test 3 done");
      report_and_stop;
   end
endmodule
bind vcat_regs vcat_regs_sva vcat_regs_sva_inst (.clk_in(clk_in), .nrst_in(nrst_in),
   .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
   .hready_in(hready_in), .upstream_port_in(upstream_port_in), .hrdata_out(hrdata_out),
   .fc_init_done_in(fc_init_done_in), .egress_port_id_in(egress_port_id_in),
   .grant_port_out(grant_port_out), .grant_valid_out(grant_valid_out),
   .grant_phase_out(grant_phase_out));
